// >>> design/ppwt_timer.v
// Pulse period / pulse width measurement timer with register port
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "ppwt_defs.vh"

// Summary of operation
// - Up-counter; effective edge copies count to reload, count restarts at 0.
// - Counting runs while start flag is one, halts when cleared.
// - Each effective edge on the measurement pin but the first of a run raises an interrupt request.
// - First effective edge after counting starts raises no interrupt request.
// - Overflow raises an interrupt request and sets the overflow flag at once.
// - Overflow flag clears only on a mode register write while started.
// - Reading the timer register returns the reload register, not the count.
// - Writes to the timer register are ignored; counter and reload unchanged.

module ppwt_timer (
  // Clock and reset
  input  wire                  sys_clk,
  input  wire                  rst,
  // Register port
  input  wire [`PPWT_AW-1:0]   addr,
  input  wire [`PPWT_DW-1:0]   wdata,
  input  wire                  wr,
  input  wire                  rd,
  output wire [`PPWT_DW-1:0]   rdata,
  // Measurement input
  input  wire                  measure_pulse_pin,
  // Status outputs
  output wire                  irq,
  output wire                  ovf_flag
);

  // Software state
  reg                  start_q;
  reg  [3:0]           mode_q;
  reg  [1:0]           mask_q;
  reg  [1:0]           stat_q;
  reg  [1:0]           stat_d;
  reg  [`PPWT_DW-1:0]  rdata_q;

  // Timer state
  reg  [`PPWT_DW-1:0]  count_q;
  reg  [`PPWT_DW-1:0]  reload_q;
  reg                  ovf_q;
  reg                  armed_q;

  // Pin synchroniser and edge history
  reg                  meas_s1_q;
  reg                  meas_s2_q;
  reg                  meas_s3_q;

  // Decoded strobes
  wire                 wr_ctrl;
  wire                 wr_mode;
  wire                 wr_stat;
  wire                 wr_mask;

  // Events
  wire                 tick;
  wire                 rise;
  wire                 fall;
  reg                  eff_edge;
  wire                 edge_irq;
  wire                 ovf_evt;
  wire [1:0]           meas_sel;

  // Address decode for writes
  assign wr_ctrl = wr && (addr == `PPWT_ADDR_CTRL);
  assign wr_mode = wr && (addr == `PPWT_ADDR_MODE);
  assign wr_stat = wr && (addr == `PPWT_ADDR_STAT);
  assign wr_mask = wr && (addr == `PPWT_ADDR_MASK);
  // The timer address has no write decode at all, so a write there
  // reaches neither the counter nor the reload register.

  assign meas_sel = mode_q[`PPWT_MODE_MEAS_HI:`PPWT_MODE_MEAS_LO];

  // Count source
  ppwt_presc u_presc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (start_q),
    .src_sel (mode_q[`PPWT_MODE_SRC_HI:`PPWT_MODE_SRC_LO]),
    .tick    (tick)
  );

  // Start flag
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_q <= `PPWT_CTRL_RST;
    end else if (wr_ctrl) begin
      start_q <= wdata[`PPWT_CTRL_START];
    end
  end

  // Mode register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q <= `PPWT_MODE_RST;
    end else if (wr_mode) begin
      mode_q <= wdata[3:0];
    end
  end

  // Interrupt mask
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= `PPWT_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= wdata[1:0];
    end
  end

  // Two-flop synchroniser; only the second and third flops feed logic
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meas_s1_q <= 1'b0;
      meas_s2_q <= 1'b0;
      meas_s3_q <= 1'b0;
    end else begin
      meas_s1_q <= measure_pulse_pin;
      meas_s2_q <= meas_s1_q;
      meas_s3_q <= meas_s2_q;
    end
  end

  assign rise = meas_s2_q && !meas_s3_q;
  assign fall = !meas_s2_q && meas_s3_q;

  // Edges are only effective while counting runs
  always @* begin
    if (!start_q) begin
      eff_edge = 1'b0;
    end else if (meas_sel == `PPWT_MEAS_PER_RISE) begin
      eff_edge = rise;
    end else if (meas_sel == `PPWT_MEAS_PER_FALL) begin
      eff_edge = fall;
    end else begin
      eff_edge = rise || fall;
    end
  end

  // Armed after the first effective edge of a run; stopping disarms
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (!start_q) begin
      armed_q <= 1'b0;
    end else if (eff_edge) begin
      armed_q <= 1'b1;
    end
  end

  assign edge_irq = eff_edge && armed_q;

  // An edge landing on the wrap tick restarts the count, so no overflow
  assign ovf_evt = start_q && tick && !eff_edge &&
                   (count_q == `PPWT_COUNT_MAX);

  // Up-counter and reload register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q  <= `PPWT_COUNT_RST;
      reload_q <= `PPWT_COUNT_RST;
    end else if (!start_q) begin
      count_q  <= count_q;
    end else if (eff_edge) begin
      reload_q <= count_q;
      count_q  <= `PPWT_COUNT_RST;
    end else if (tick) begin
      count_q  <= count_q + 16'h0001;
    end
  end

  // Overflow flag; a new overflow wins over a clearing mode write
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_q <= 1'b1;
    end else if (wr_mode && start_q) begin
      ovf_q <= 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always @* begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wdata[1:0];
    end
    if (edge_irq) begin
      stat_d[`PPWT_INT_EDGE] = 1'b1;
    end
    if (ovf_evt) begin
      stat_d[`PPWT_INT_OVF] = 1'b1;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_q <= `PPWT_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Read data, valid the cycle after the strobe only
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (!rd) begin
      rdata_q <= 16'h0000;
    end else if (addr == `PPWT_ADDR_CTRL) begin
      rdata_q <= {15'h0000, start_q};
    end else if (addr == `PPWT_ADDR_MODE) begin
      rdata_q <= {12'h000, mode_q};
    end else if (addr == `PPWT_ADDR_TIMER) begin
      // Until the second edge this holds a partial or stale count
      rdata_q <= reload_q;
    end else if (addr == `PPWT_ADDR_STAT) begin
      rdata_q <= {14'h0000, stat_q};
    end else if (addr == `PPWT_ADDR_MASK) begin
      rdata_q <= {14'h0000, mask_q};
    end else if (addr == `PPWT_ADDR_FLAGS) begin
      rdata_q <= {14'h0000, armed_q, ovf_q};
    end else if (addr == `PPWT_ADDR_COUNT) begin
      rdata_q <= count_q;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata    = rdata_q;
  assign irq      = |(stat_q & mask_q);
  assign ovf_flag = ovf_q;

endmodule

// >>> design/ppwt_defs.vh
// Constants for the pulse period / pulse width measurement timer
`ifndef PPWT_DEFS_VH
`define PPWT_DEFS_VH

// Bus widths
`define PPWT_AW              8
`define PPWT_DW              16

// Register byte offsets
`define PPWT_ADDR_CTRL       8'h00
`define PPWT_ADDR_MODE       8'h04
`define PPWT_ADDR_TIMER      8'h08
`define PPWT_ADDR_STAT       8'h0C
`define PPWT_ADDR_MASK       8'h10
`define PPWT_ADDR_FLAGS      8'h14
`define PPWT_ADDR_COUNT      8'h18

// Field positions
`define PPWT_CTRL_START      0
`define PPWT_MODE_SRC_LO     0
`define PPWT_MODE_SRC_HI     1
`define PPWT_MODE_MEAS_LO    2
`define PPWT_MODE_MEAS_HI    3
`define PPWT_INT_EDGE        0
`define PPWT_INT_OVF         1
`define PPWT_FLAGS_OVF       0
`define PPWT_FLAGS_ARMED     1

// Reset values
`define PPWT_CTRL_RST        1'h0
`define PPWT_MODE_RST        4'h0
`define PPWT_MASK_RST        2'h0
`define PPWT_STAT_RST        2'h0
`define PPWT_COUNT_RST       16'h0000
`define PPWT_COUNT_MAX       16'hFFFF

// Measurement selections
`define PPWT_MEAS_PER_RISE   2'h0
`define PPWT_MEAS_PER_FALL   2'h1

// Count source selections and their divide ratios in sys_clk cycles
`define PPWT_SRC_F2          2'h0
`define PPWT_SRC_F8          2'h1
`define PPWT_SRC_F32         2'h2
`define PPWT_DIV_F2          7'h02
`define PPWT_DIV_F8          7'h08
`define PPWT_DIV_F32         7'h20
`define PPWT_DIV_FC32        7'h40

`endif

// >>> design/ppwt_presc.v
// Count source prescaler: one-cycle tick at the selected rate
`timescale 1ns/100ps
`include "ppwt_defs.vh"

module ppwt_presc (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Control
  input  wire       run,
  input  wire [1:0] src_sel,
  // Count enable
  output wire       tick
);

  reg  [6:0] div;
  reg  [6:0] cnt_q;
  reg        tick_q;

  always @* begin
    case (src_sel)
      `PPWT_SRC_F2:  div = `PPWT_DIV_F2;
      `PPWT_SRC_F8:  div = `PPWT_DIV_F8;
      `PPWT_SRC_F32: div = `PPWT_DIV_F32;
      default:       div = `PPWT_DIV_FC32;
    endcase
  end

  // Held in reset while stopped so the first tick after start is full length
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 7'h00;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q  <= 7'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= div - 7'h01) begin
      cnt_q  <= 7'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule

// >>> tb/ppwt_pulse_src.sv
// External pulse source model driving the measurement pin
`timescale 1ns/100ps

module ppwt_pulse_src (
  // Clock
  input  wire        sys_clk,
  // Bench control
  input  wire        run,
  input  wire [15:0] half,
  // Pulse out
  output reg         measure_pulse_pin
);
  reg [15:0] cnt_q;

  initial begin
    measure_pulse_pin = 1'b0;
    cnt_q = 16'h0001;
  end

  // Rests low when idle; even halves of one clock reach the edge detector
  always @(posedge sys_clk) begin
    if (!run || cnt_q >= half) begin
      measure_pulse_pin <= run & ~measure_pulse_pin;
      cnt_q <= 16'h0001;
    end else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule

// >>> tb/ppwt_timer_assertions.sv
// Port checker for the measurement timer
`timescale 1ns/100ps
`include "ppwt_defs.vh"

module ppwt_chk (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst,
  // Register port
  input wire [7:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  // Status
  input wire        irq,
  input wire        ovf_flag
);
  reg  run_q;
  wire mode_wr = wr && addr == `PPWT_ADDR_MODE;
  wire clr_ok = mode_wr && run_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Start flag has no port, so it is shadowed from CTRL writes
  always @(posedge sys_clk or posedge rst)
    if (rst) run_q <= 1'b0;
    else if (wr && addr == `PPWT_ADDR_CTRL) run_q <= wdata[0];

  rd_idle_a: assert property (!rd |=> !rdata)
    else $error("rdata not idle");
  rd_unmap_a: assert property (rd && addr == 8'h1C |=> !rdata)
    else $error("unmapped read not zero");
  flags_rd_a: assert property (rd && addr == `PPWT_ADDR_FLAGS |=>
    rdata[0] == $past(ovf_flag) && rdata[15:2] == 14'h0000)
    else $error("flags read wrong");
  ovf_hold_a: assert property (ovf_flag && !mode_wr |=> ovf_flag)
    else $error("overflow flag dropped");
  ovf_clr_a: assert property ($fell(ovf_flag) |-> $past(clr_ok))
    else $error("overflow flag cleared wrongly");
  ovf_stop_a: assert property (!run_q && !ovf_flag |=> !ovf_flag)
    else $error("overflow while stopped");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr))
    else $error("irq fell without write");
  irq_stop_a: assert property (!run_q && !irq && !wr |=> !irq)
    else $error("irq while stopped");

  edge_irq_c: cover property ($rose(irq));
  ovf_set_c: cover property ($rose(ovf_flag));
  ovf_clr_c: cover property ($fell(ovf_flag));
endmodule

bind ppwt_timer ppwt_chk u_chk (.sys_clk(sys_clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
  .ovf_flag(ovf_flag));

// >>> tb/test_ppwt_timer.sv
// Self-checking bench for the measurement timer
`timescale 1ns/100ps
`include "ppwt_defs.vh"

module test_ppwt_timer;
  reg         sys_clk, rst, wr, rd, src_run;
  reg  [7:0]  addr;
  reg  [15:0] wdata, src_half, v, w;
  wire [15:0] rdata;
  wire        pin, irq, ovf_flag;
  integer     mismatches, n_tests, cycles, m, i;

  ppwt_timer dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .measure_pulse_pin(pin), .irq(irq),
    .ovf_flag(ovf_flag));
  ppwt_pulse_src src (.sys_clk(sys_clk), .run(src_run), .half(src_half),
    .measure_pulse_pin(pin));

  always #20 sys_clk = ~sys_clk;

  task summarize;
    begin
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // Ceiling leaves margin over one full 16-bit wrap at the fastest source
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 150000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end

  task chk(input [15:0] got, input [15:0] lo, input [15:0] hi);
    begin
      n_tests = n_tests + 1;
      if ((got >= lo && got <= hi) !== 1'b1) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
    end
  endtask

  task wreg(input [7:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      #1;
    end
  endtask

  task rreg(input [7:0] a, output [15:0] d);
    begin
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
    end
  endtask

  task t_reset;
    begin
      for (m = 0; m < 8; m = m + 1) begin
        rreg(8'(m * 4), v);
        chk(v, 16'h0000, 16'h0000);
      end
      chk({14'h0000, ovf_flag, irq}, 16'h0000, 16'h0000);
    end
  endtask

  task t_measure;
    begin
      for (m = 0; m < 4; m = m + 1) begin
        wreg(`PPWT_ADDR_MODE, {12'h000, m[1:0], `PPWT_SRC_F8});
        wreg(`PPWT_ADDR_CTRL, 16'h0001);
        src_run <= 1'b1;
        repeat (600) @(posedge sys_clk);
        wreg(`PPWT_ADDR_TIMER, 16'hABCD);
        rreg(`PPWT_ADDR_TIMER, v);
        w = (m < 2) ? 16'h0010 : 16'h0008;
        chk(v, w - 16'h0001, w);
        src_run <= 1'b0;
        wreg(`PPWT_ADDR_CTRL, 16'h0000);
      end
    end
  endtask

  task t_first;
    begin
      wreg(`PPWT_ADDR_MODE, {12'h000, `PPWT_MEAS_PER_RISE, `PPWT_SRC_F2});
      wreg(`PPWT_ADDR_STAT, 16'h0003);
      wreg(`PPWT_ADDR_MASK, 16'h0001);
      wreg(`PPWT_ADDR_CTRL, 16'h0001);
      src_half <= 16'h0010;
      for (i = 0; i < 2; i = i + 1) begin
        src_run <= 1'b1;
        repeat (24) @(posedge sys_clk);
        src_run <= 1'b0;
        rreg(`PPWT_ADDR_STAT, v);
        chk(v, i[15:0], i[15:0]);
        chk({15'h0000, irq}, i[15:0], i[15:0]);
      end
      wreg(`PPWT_ADDR_STAT, 16'h0001);
      chk({15'h0000, irq}, 16'h0000, 16'h0000);
    end
  endtask

  task t_ovf;
    begin
      wreg(`PPWT_ADDR_MASK, 16'h0002);
      i = 0;
      while (ovf_flag !== 1'b1 && i < 140000) begin
        @(posedge sys_clk);
        i = i + 1;
      end
      #1;
      chk({14'h0000, ovf_flag, irq}, 16'h0003, 16'h0003);
      wreg(`PPWT_ADDR_CTRL, 16'h0000);
      wreg(`PPWT_ADDR_MODE, 16'h0000);
      chk({15'h0000, ovf_flag}, 16'h0001, 16'h0001);
      rreg(`PPWT_ADDR_COUNT, v);
      repeat (20) @(posedge sys_clk);
      rreg(`PPWT_ADDR_COUNT, w);
      chk(w, v, v);
      wreg(`PPWT_ADDR_CTRL, 16'h0001);
      wreg(`PPWT_ADDR_MODE, 16'h0000);
      chk({15'h0000, ovf_flag}, 16'h0000, 16'h0000);
      wreg(`PPWT_ADDR_STAT, 16'h0002);
      chk({15'h0000, irq}, 16'h0000, 16'h0000);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {wr, rd, src_run, addr, wdata} = 27'h0000000;
    src_half = 16'h0040;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_measure;
    t_first;
    t_ovf;
    summarize;
  end
endmodule
